/* File: design/dmcr_pkg.sv */
package dmcr_pkg;
  // register addresses on the serial control port
  localparam logic [4:0] A_PORT = 5'h00;
  localparam logic [4:0] A_FILT = 5'h01;
  localparam logic [4:0] A_DATA = 5'h02;
  localparam logic [4:0] A_MOD = 5'h03;
  localparam logic [4:0] A_MULT = 5'h04;
  localparam logic [4:0] A_OFFS = 5'h05;
  localparam logic [4:0] A_REV = 5'h0d;
  localparam logic [4:0] A_CALCK = 5'h0e;
  localparam logic [4:0] A_CMD = 5'h0f;
  localparam logic [4:0] A_PTR = 5'h10;
  localparam logic [4:0] A_WORD = 5'h11;
  localparam logic [4:0] A_DCR = 5'h12;
  // writable bits per register
  localparam logic [7:0] M_PORT = 8'hd9;
  localparam logic [7:0] M_FILT = 8'hcf;
  localparam logic [7:0] M_MOD = 8'hfc;
  localparam logic [7:0] M_CALCK = 8'h37;
  localparam logic [7:0] M_CMD = 8'h5f;
  localparam logic [7:0] M_WORD = 8'h3f;
  // every writable register defaults to zero
  localparam logic [7:0] DEF_REG = 8'h00;
  // revision code: arbitrary value
  localparam logic [3:0] REV_CODE = 4'h1;
  // register 0x00 fields
  localparam int B_DIR = 7;
  localparam int B_ORDER = 6;
  localparam int B_SOFT_REGISTER_RESET = 5;
  localparam int B_SLEEP = 4;
  localparam int B_PDN = 3;
  localparam int B_LOCK = 1;
  localparam int B_EXTERNAL_REFERENCE_SELECT = 0;
  // register 0x02 fields
  localparam int B_CODING = 7;
  localparam int B_INTERLEAVED_PORT_MODE = 6;
  localparam int B_DRIVE = 5;
  localparam int B_EDGE = 4;
  localparam int B_CLKDIR = 3;
  localparam int B_RECOV = 2;
  localparam int B_IQ_SELECT_POLARITY = 1;
  localparam int B_GRAY = 0;
  // register 0x04 and 0x0f fields
  localparam int B_MULT_EN = 7;
  localparam int B_LOCK_OUT = 0;
  localparam int B_CAL_STAT = 7;
  localparam int B_XFER_STAT = 5;
  // instruction byte fields
  localparam int B_RW = 7;

  typedef enum logic [1:0] {
    PH_INSTR = 2'b00,
    PH_DATA = 2'b01,
    PH_DONE = 2'b10
  } dmcr_phase_t;

  typedef struct packed {
    dmcr_phase_t phase;
    logic sclk;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic rd;
    logic [1:0] left;
    logic [4:0] addr;
    logic dout;
    logic soft_register_reset;
    logic [7:0] r_port;
    logic [7:0] r_filt;
    logic [7:0] r_data;
    logic [7:0] r_mod;
    logic [7:0] r_mult;
    logic [7:0] r_offs;
    logic [7:0] r_calck;
    logic [7:0] r_cmd;
    logic [7:0] r_ptr;
    logic [7:0] r_word;
  } dmcr_state_t;
endpackage : dmcr_pkg

/* File: design/dmcr_regs.sv */
// How it works
// RULE1 - host reads and writes the mode registers over the serial port
// RULE2 - port reg bit 7 makes the data pin drive read data in place of the output pin
// RULE3 - port reg bit 6 picks msb-first (0) or lsb-first (1) bit order
// RULE4 - soft reset bit defaults all registers except 0x00 and 0x04
// RULE5 - port reg bit 4 switches converter output current off
// RULE6 - port reg bit 3 powers down everything but the serial port
// RULE7 - port reg bit 1 reads multiplier lock while multiplier is on
// RULE8 - port reg bit 0 selects external reference, else internal bandgap
// RULE9 - filter reg bits 7:6 set interpolation none, 2x, 4x, 8x
// RULE10 - filter reg bits 2:0 high-pass per filter, bit 3 zero stuffing
// RULE11 - data reg bit 7 unsigned coding, bit 0 gray decode enable
// RULE12 - data reg bit 6 interleaves I and Q on port one
// RULE13 - data reg bit 4 latches samples on falling clock edge
// RULE14 - data reg bit 3 drives sample clock pin out, lock option off
// RULE15 - data reg bit 2 enables clock recovery on an input clock pin
// RULE16 - data reg bit 1 swaps I/Q select polarity in one-port mode
// RULE17 - access opens with instruction: read bit, length, start address
// RULE18 - each register updates on the last bit of its byte
// RULE19 - reserved addresses and bits ignore writes and read zero
// RULE20 - sleep, power-down and soft reset act at that byte boundary
`timescale 1ns/100ps
module dmcr_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  input wire logic multiplier_lock_i,
  input wire logic calibration_state_flag_i,
  input wire logic transfer_state_flag_i,
  input wire logic [2:0] clock_recovery_state_i,
  output logic soft_register_reset_o,
  output logic output_current_off_o,
  output logic full_power_down_o,
  output logic external_reference_select_o,
  output logic [1:0] interpolation_factor_o,
  output logic zero_insertion_enable_o,
  output logic x8_filter_highpass_o,
  output logic x4_filter_highpass_o,
  output logic x2_filter_highpass_o,
  output logic sample_coding_select_o,
  output logic interleaved_port_mode_o,
  output logic clock_pin_drive_select_o,
  output logic capture_edge_select_o,
  output logic sample_clock_pin_direction_o,
  output logic sample_clock_recovery_enable_o,
  output logic iq_select_polarity_o,
  output logic gray_input_decode_enable_o,
  output logic multiplier_lock_indicator_o,
  output logic [7:0] modulator_config_o,
  output logic [7:0] clock_multiplier_config_o,
  output logic [7:0] sample_clock_offset_adjust_o,
  output logic [7:0] calibration_memory_clocking_o,
  output logic [7:0] calibration_memory_command_o,
  output logic [7:0] calibration_memory_pointer_o,
  output logic [7:0] calibration_memory_word_o
);
  import dmcr_pkg::*;

  dmcr_state_t q_ff;
  dmcr_state_t nxt_q;
  logic lock_flag;
  logic lock_opt;
  logic [7:0] rd_byte;
  logic [7:0] new_byte;
  logic sclk_rise;
  logic sclk_fall;
  logic [2:0] out_idx;
  logic reading;

  // lock only means something while the multiplier runs
  assign lock_flag = multiplier_lock_i & q_ff.r_mult[B_MULT_EN]; // RULE7
  assign lock_opt = q_ff.r_mult[B_MULT_EN] & q_ff.r_mult[B_LOCK_OUT];

  // sclk is sampled on clk_i, so it must run below half of clk_i
  assign sclk_rise = sclk_i & ~q_ff.sclk;
  assign sclk_fall = ~sclk_i & q_ff.sclk;

  always_comb begin
    if (q_ff.r_port[B_ORDER]) begin
      new_byte = {sdio_i, q_ff.sh[7:1]}; // RULE3
    end else begin
      new_byte = {q_ff.sh[6:0], sdio_i}; // RULE3
    end
  end

  always_comb begin
    case (q_ff.addr)
      A_PORT: begin
        rd_byte = {q_ff.r_port[7:2], lock_flag, q_ff.r_port[0]}; // RULE7
      end
      A_FILT: begin
        rd_byte = q_ff.r_filt;
      end
      A_DATA: begin
        rd_byte = q_ff.r_data;
      end
      A_MOD: begin
        rd_byte = q_ff.r_mod;
      end
      A_MULT: begin
        rd_byte = q_ff.r_mult;
      end
      A_OFFS: begin
        rd_byte = q_ff.r_offs;
      end
      A_REV: begin
        rd_byte = {4'h0, REV_CODE};
      end
      A_CALCK: begin
        rd_byte = q_ff.r_calck;
      end
      A_CMD: begin
        rd_byte = q_ff.r_cmd;
        rd_byte[B_CAL_STAT] = calibration_state_flag_i;
        rd_byte[B_XFER_STAT] = transfer_state_flag_i;
      end
      A_PTR: begin
        rd_byte = q_ff.r_ptr;
      end
      A_WORD: begin
        rd_byte = q_ff.r_word;
      end
      A_DCR: begin
        rd_byte = {5'h00, clock_recovery_state_i};
      end
      default: begin
        rd_byte = 8'h00; // RULE19
      end
    endcase
  end

  // next bit out follows the bit order currently in force
  assign out_idx = q_ff.r_port[B_ORDER] ? q_ff.bit_cnt : 3'h7 - q_ff.bit_cnt;
  assign reading = ~cs_n_i & q_ff.rd & (q_ff.phase == PH_DATA);

  always_comb begin
    nxt_q = q_ff;
    nxt_q.sclk = sclk_i;
    nxt_q.soft_register_reset = 1'b0;
    if (cs_n_i) begin
      // a raised select abandons any partial byte
      nxt_q.phase = PH_INSTR;
      nxt_q.bit_cnt = 3'h0;
      nxt_q.rd = 1'b0;
    end else begin
      if (sclk_fall && q_ff.rd && q_ff.phase == PH_DATA) begin
        nxt_q.dout = rd_byte[out_idx];
      end
      if (sclk_rise) begin
        nxt_q.sh = new_byte;
        nxt_q.bit_cnt = q_ff.bit_cnt + 3'h1;
        if (q_ff.bit_cnt == 3'h7) begin
          case (q_ff.phase)
            PH_INSTR: begin
              nxt_q.rd = new_byte[B_RW]; // RULE17
              nxt_q.left = new_byte[6:5]; // RULE17
              nxt_q.addr = new_byte[4:0]; // RULE17
              nxt_q.phase = PH_DATA;
            end
            PH_DATA: begin
              if (!q_ff.rd) begin
                // the byte lands now, not at the end of the access
                case (q_ff.addr) // RULE18
                  A_PORT: begin
                    nxt_q.r_port = new_byte & M_PORT; // RULE1
                    nxt_q.soft_register_reset = new_byte[B_SOFT_REGISTER_RESET]; // RULE20
                  end
                  A_FILT: begin
                    nxt_q.r_filt = new_byte & M_FILT; // RULE19
                  end
                  A_DATA: begin
                    nxt_q.r_data = new_byte;
                  end
                  A_MOD: begin
                    nxt_q.r_mod = new_byte & M_MOD;
                  end
                  A_MULT: begin
                    nxt_q.r_mult = new_byte;
                  end
                  A_OFFS: begin
                    nxt_q.r_offs = new_byte;
                  end
                  A_CALCK: begin
                    nxt_q.r_calck = new_byte & M_CALCK;
                  end
                  A_CMD: begin
                    nxt_q.r_cmd = new_byte & M_CMD;
                  end
                  A_PTR: begin
                    nxt_q.r_ptr = new_byte;
                  end
                  A_WORD: begin
                    nxt_q.r_word = new_byte & M_WORD;
                  end
                  default: begin
                    nxt_q.sh = new_byte; // RULE19
                  end
                endcase
                if (q_ff.addr == A_PORT && new_byte[B_SOFT_REGISTER_RESET]) begin
                  nxt_q.r_filt = DEF_REG; // RULE4
                  nxt_q.r_data = DEF_REG; // RULE4
                  nxt_q.r_mod = DEF_REG;
                  nxt_q.r_offs = DEF_REG;
                  nxt_q.r_calck = DEF_REG;
                  nxt_q.r_cmd = DEF_REG;
                  nxt_q.r_ptr = DEF_REG;
                  nxt_q.r_word = DEF_REG;
                end
              end
              // order takes effect for the rest of the access
              if (nxt_q.r_port[B_ORDER]) begin
                nxt_q.addr = q_ff.addr + 5'h01; // RULE3
              end else begin
                nxt_q.addr = q_ff.addr - 5'h01; // RULE3
              end
              if (q_ff.left == 2'h0) begin
                nxt_q.phase = PH_DONE;
              end else begin
                nxt_q.left = q_ff.left - 2'h1;
              end
            end
            default: begin
              nxt_q.phase = PH_DONE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // read data goes on one pin or the other, never both
  assign sdio_o = q_ff.dout;
  assign sdo_o = q_ff.dout;
  assign sdio_oe_n_o = ~(reading & q_ff.r_port[B_DIR]); // RULE2
  assign sdo_oe_n_o = ~(reading & ~q_ff.r_port[B_DIR]); // RULE2

  assign soft_register_reset_o = q_ff.soft_register_reset; // RULE4
  assign output_current_off_o = q_ff.r_port[B_SLEEP]; // RULE5
  assign full_power_down_o = q_ff.r_port[B_PDN]; // RULE6
  assign external_reference_select_o = q_ff.r_port[B_EXTERNAL_REFERENCE_SELECT]; // RULE8
  assign multiplier_lock_indicator_o = lock_flag; // RULE7
  assign interpolation_factor_o = q_ff.r_filt[7:6]; // RULE9
  assign zero_insertion_enable_o = q_ff.r_filt[3]; // RULE10
  assign x8_filter_highpass_o = q_ff.r_filt[2]; // RULE10
  assign x4_filter_highpass_o = q_ff.r_filt[1]; // RULE10
  assign x2_filter_highpass_o = q_ff.r_filt[0]; // RULE10
  assign sample_coding_select_o = q_ff.r_data[B_CODING]; // RULE11
  assign gray_input_decode_enable_o = q_ff.r_data[B_GRAY]; // RULE11
  assign interleaved_port_mode_o = q_ff.r_data[B_INTERLEAVED_PORT_MODE]; // RULE12
  assign clock_pin_drive_select_o = q_ff.r_data[B_DRIVE];
  assign capture_edge_select_o = q_ff.r_data[B_EDGE]; // RULE13
  // with the lock option on, the pin carries lock, not the clock
  assign sample_clock_pin_direction_o = q_ff.r_data[B_CLKDIR] & ~lock_opt; // RULE14
  assign sample_clock_recovery_enable_o =
    q_ff.r_data[B_RECOV] & ~q_ff.r_data[B_CLKDIR] & ~lock_opt; // RULE15
  // polarity only steers samples in one-port mode
  assign iq_select_polarity_o = q_ff.r_data[B_IQ_SELECT_POLARITY] & q_ff.r_data[B_INTERLEAVED_PORT_MODE]; // RULE16
  assign modulator_config_o = q_ff.r_mod;
  assign clock_multiplier_config_o = q_ff.r_mult;
  assign sample_clock_offset_adjust_o = q_ff.r_offs;
  assign calibration_memory_clocking_o = q_ff.r_calck;
  assign calibration_memory_command_o = q_ff.r_cmd;
  assign calibration_memory_pointer_o = q_ff.r_ptr;
  assign calibration_memory_word_o = q_ff.r_word;
endmodule : dmcr_regs

/* File: testbench/dmcr_regs_monitor.sv */
`timescale 1ns/100ps
module dmcr_regs_monitor (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic sdio_oe_n_o,
  input wire logic sdo_oe_n_o,
  input wire logic multiplier_lock_i,
  input wire logic multiplier_lock_indicator_o,
  input wire logic [7:0] clock_multiplier_config_o,
  input wire logic iq_select_polarity_o,
  input wire logic interleaved_port_mode_o,
  input wire logic sample_clock_recovery_enable_o,
  input wire logic sample_clock_pin_direction_o,
  input wire logic soft_register_reset_o,
  input wire logic [1:0] interpolation_factor_o,
  input wire logic [7:0] modulator_config_o,
  input wire logic [7:0] calibration_memory_pointer_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  hiz_idle_a: assert property (cs_n_i && $past(cs_n_i) |-> sdio_oe_n_o && sdo_oe_n_o)
    else $error("data pin driven while deselected");
  one_driver_a: assert property (sdio_oe_n_o || sdo_oe_n_o)
    else $error("both data pins driven");
  lock_flag_a: assert property (multiplier_lock_indicator_o ==
    (multiplier_lock_i && clock_multiplier_config_o[7])) else $error("lock flag wrong");
  iq_pol_a: assert property (iq_select_polarity_o |-> interleaved_port_mode_o)
    else $error("iq polarity outside one-port mode");
  recov_gate_a: assert property (sample_clock_recovery_enable_o |->
    !sample_clock_pin_direction_o && !(clock_multiplier_config_o[7] && clock_multiplier_config_o[0]))
    else $error("clock recovery not gated");
  pin_dir_a: assert property (sample_clock_pin_direction_o |->
    !(clock_multiplier_config_o[7] && clock_multiplier_config_o[0])) else $error("pin dir");
  soft_register_reset_pulse_a: assert property ($rose(soft_register_reset_o) |=> !soft_register_reset_o)
    else $error("soft reset not a pulse");
  soft_register_reset_clear_a: assert property (soft_register_reset_o |-> ##1
    (interpolation_factor_o == 2'h0 && calibration_memory_pointer_o == 8'h00))
    else $error("soft reset left registers set");
  soft_register_reset_keep_a: assert property (soft_register_reset_o |-> $stable(clock_multiplier_config_o))
    else $error("soft reset hit multiplier config");
  idle_stable_a: assert property (cs_n_i && $past(cs_n_i, 2) |->
    $stable(modulator_config_o) && $stable(interpolation_factor_o)) else $error("idle change");
  cover property (soft_register_reset_o);
  cover property (!sdio_oe_n_o);
  cover property (!sdo_oe_n_o);
endmodule : dmcr_regs_monitor
bind dmcr_regs dmcr_regs_monitor dmcr_regs_monitor_inst (.*);

/* File: testbench/dmcr_host.sv */
`timescale 1ns/100ps
module dmcr_host (
  input wire logic clk_i,
  input wire logic sdio_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdio_o = 1'b0;
  end
  // four clocks per half period, four times the minimum the port can track
  task automatic half();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : half
  task automatic shift(input logic [7:0] tx, input bit lsb, input bit tw, output logic [7:0] rx);
    int j;
    for (int i = 0; i < 8; i++) begin
      j = lsb ? i : 7 - i;
      sclk_o = 1'b0;
      sdio_o = tx[j];
      half();
      rx[j] = tw ? sdio_i : sdo_i;
      sclk_o = 1'b1;
      half();
    end
  endtask : shift
  task automatic xfer(input bit rd, input logic [4:0] a, input int n, input logic [31:0] wd,
                      input bit lsb, input bit tw, output logic [31:0] rv);
    logic [7:0] d;
    rv = 32'h0;
    cs_n_o = 1'b0;
    shift({rd, 2'(n - 1), a}, lsb, tw, d);
    for (int k = 0; k < n; k++) begin
      // while reading, the released line toggles so a stale bit never passes
      shift(rd ? 8'h55 : wd[8*k+:8], lsb, tw, d);
      rv[8*k+:8] = d;
    end
    sclk_o = 1'b0;
    half();
    cs_n_o = 1'b1;
    sdio_o = ~sdio_o;
    half();
  endtask : xfer
  // write access cut after half a data byte: nothing may land
  task automatic cut(input logic [4:0] a);
    logic [7:0] d;
    cs_n_o = 1'b0;
    shift({3'h0, a}, 1'b0, 1'b0, d);
    for (int i = 0; i < 4; i++) begin
      sclk_o = 1'b0;
      sdio_o = 1'b1;
      half();
      sclk_o = 1'b1;
      half();
    end
    sclk_o = 1'b0;
    half();
    cs_n_o = 1'b1;
    half();
  endtask : cut
endmodule : dmcr_host

/* File: testbench/dmcr_regs_tb.sv */
`timescale 1ns/100ps
module dmcr_regs_tb;
  import dmcr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic multiplier_lock_i = 1'b0;
  logic calibration_state_flag_i = 1'b0;
  logic transfer_state_flag_i = 1'b0;
  logic [2:0] clock_recovery_state_i = 3'h0;
  logic sclk_i, cs_n_i, sdio_i, h_sdio, sdio_o, sdio_oe_n_o, sdo_o, sdo_oe_n_o;
  logic soft_register_reset_o, output_current_off_o, full_power_down_o;
  logic external_reference_select_o, zero_insertion_enable_o, x8_filter_highpass_o;
  logic x4_filter_highpass_o, x2_filter_highpass_o, sample_coding_select_o;
  logic interleaved_port_mode_o, clock_pin_drive_select_o, capture_edge_select_o;
  logic sample_clock_pin_direction_o, sample_clock_recovery_enable_o, iq_select_polarity_o;
  logic gray_input_decode_enable_o, multiplier_lock_indicator_o;
  logic [1:0] interpolation_factor_o;
  logic [7:0] modulator_config_o, clock_multiplier_config_o, sample_clock_offset_adjust_o;
  logic [7:0] calibration_memory_clocking_o, calibration_memory_command_o;
  logic [7:0] calibration_memory_pointer_o, calibration_memory_word_o;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  bit lsb = 0;
  bit tw = 0;
  logic [31:0] rv;
  logic [7:0] d;
  logic [7:0] msk [19];
  logic sdo_line;
  // the wire level: the device wins only while it enables its driver
  assign sdio_i = sdio_oe_n_o ? h_sdio : sdio_o;
  // a released output shows the inverse, so a missing enable cannot pass
  assign sdo_line = sdo_oe_n_o ? ~sdo_o : sdo_o;
  dmcr_regs dmcr_regs_inst (.*);
  dmcr_host dmcr_host_inst (.clk_i(clk_i), .sdio_i(sdio_i), .sdo_i(sdo_line), .sclk_o(sclk_i),
    .cs_n_o(cs_n_i), .sdio_o(h_sdio));
  always #50 clk_i = ~clk_i;
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input int n = 1);
    dmcr_host_inst.xfer(1'b0, a, n, v, lsb, tw, rv);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input int n = 1);
    dmcr_host_inst.xfer(1'b1, a, n, 32'h0, lsb, tw, rv);
    chk(rv, e);
  endtask : rd
  initial begin
    msk = '{8'h00, M_FILT, 8'hff, M_MOD, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, {4'h0, REV_CODE}, M_CALCK, M_CMD, 8'hff, M_WORD, 8'h00};
    repeat (3) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    @(posedge clk_i);
    #1;
    for (int a = 0; a < 19; a++) rd(5'(a), (a == 13) ? {28'h0, REV_CODE} : 32'h0);
    for (int a = 1; a < 19; a++) begin
      wr(5'(a), 32'hff);
      rd(5'(a), {24'h0, msk[a]});
    end
    chk({modulator_config_o, clock_multiplier_config_o, sample_clock_offset_adjust_o,
      calibration_memory_clocking_o}, {M_MOD, 8'hff, 8'hff, M_CALCK});
    chk({calibration_memory_command_o, calibration_memory_pointer_o,
      calibration_memory_word_o}, {M_CMD, 8'hff, M_WORD});
    for (int c = 0; c < 4; c++) begin
      wr(A_FILT, {24'h0, c[1:0], c[0] ? 6'h0a : 6'h05});
      chk({interpolation_factor_o, zero_insertion_enable_o, x8_filter_highpass_o,
        x4_filter_highpass_o, x2_filter_highpass_o}, {c[1:0], c[0] ? 4'ha : 4'h5});
    end
    for (int k = 0; k < 4; k++) begin
      d = k[0] ? 8'hb7 : 8'h4e;
      wr(A_MULT, k[1] ? 32'h81 : 32'h80);
      wr(A_DATA, {24'h0, d});
      chk({sample_coding_select_o, interleaved_port_mode_o, clock_pin_drive_select_o,
        capture_edge_select_o, sample_clock_pin_direction_o, sample_clock_recovery_enable_o,
        iq_select_polarity_o, gray_input_decode_enable_o}, {d[7:4], d[3] & !k[1],
        d[2] & !d[3] & !k[1], d[1] & d[6], d[0]});
    end
    multiplier_lock_i = 1'b1;
    calibration_state_flag_i = 1'b1;
    transfer_state_flag_i = 1'b1;
    clock_recovery_state_i = 3'h5;
    wr(A_CMD, 32'h0);
    rd(A_PORT, 32'h02);
    rd(A_CMD, 32'ha0);
    rd(A_DCR, 32'h05);
    wr(A_MULT, 32'h0);
    rd(A_PORT, 32'h0);
    wr(A_PORT, 32'h19);
    chk({output_current_off_o, full_power_down_o, external_reference_select_o}, 3'h7);
    wr(A_MULT, 32'h80);
    wr(A_FILT, 32'hff);
    wr(A_PORT, 32'h30);
    chk({output_current_off_o, full_power_down_o, interpolation_factor_o}, 4'h8);
    rd(A_PORT, 32'h12);
    rd(A_FILT, 32'h0);
    rd(A_MULT, 32'h80);
    dmcr_host_inst.cut(A_FILT);
    rd(A_FILT, 32'h0);
    wr(A_DATA, 32'h3c5a, 2);
    rd(A_DATA, 32'h0c5a, 2);
    wr(A_PORT, 32'h40);
    lsb = 1;
    wr(A_FILT, 32'h8381, 2);
    rd(A_FILT, 32'h8381, 2);
    rd(A_PORT, 32'h42);
    wr(A_PORT, 32'h80);
    lsb = 0;
    tw = 1;
    rd(A_FILT, 32'h81);
    rd(A_PORT, 32'h82);
    reset_n_i = 1'b0;
    @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    tw = 0;
    @(posedge clk_i);
    #1;
    rd(A_FILT, 32'h0);
    rd(A_PORT, 32'h0);
    give_verdict();
  end
endmodule : dmcr_regs_tb
